/* File: design/lipr_regs.sv */
// Primary register bank of a quad line interface over Wishbone
`timescale 1ns/1ps
`default_nettype none
module lipr_regs (
    input  wire logic                         clk_i,   // 10 MHz clock
    input  wire logic                         rst_i,   // Sync reset
    input  wire logic                         cyc_i,   // Bus cycle
    input  wire logic                         stb_i,   // Bus strobe
    input  wire logic                         we_i,    // Write
    input  wire logic [lipr_pkg::ADR_W-1:0]   adr_i,   // Byte address
    input  wire logic [lipr_pkg::SEL_W-1:0]   sel_i,   // Byte enables
    input  wire logic [lipr_pkg::DAT_W-1:0]   dat_i,   // Write data
    output logic      [lipr_pkg::DAT_W-1:0]   dat_o,   // Read data
    output logic                              ack_o,   // Acknowledge
    input  wire logic [lipr_pkg::NCH-1:0]     no_signal_alarm_i, // Loss
    input  wire logic [lipr_pkg::NCH-1:0]     ais_detect_i,      // ALARM_INDICATION_STATUS seen
    output logic      [lipr_pkg::NCH-1:0]     all_ones_o,   // Send ones
    output logic      [lipr_pkg::NCH-1:0]     ais_insert_o, // ALARM_INDICATION_STATUS to sys
    output logic                              short_prot_en_o, // SCP on
    output logic                              ami_sel_o,   // AMI coding
    output logic                              fifo_deep_o, // 64-bit FIFO
    output logic                              bw_high_o,   // High corner
    output logic                              ja_tx_o,     // JA in tx
    output logic                              ja_rx_o,     // JA in rx
    output logic [lipr_pkg::NCH*lipr_pkg::TMPL_W-1:0] template_o, // Codes
    output logic      [lipr_pkg::NCH-1:0]     driver_hiz_o, // Driver off
    output logic                              bank_exp_o,  // Expanded
    output logic                              srst_busy_o, // Soft reset
    output logic                              irq_o        // Interrupt
);
    import lipr_pkg::*;

    logic                ack_r;
    logic [DAT_W-1:0]    dat_r;
    lipr_srst_t          srst_state_r;
    lipr_srst_t          srst_state_nxt;
    logic [3:0]          srst_cnt_r;
    logic [NCH-1:0]      auto_ones_r;
    logic [CFG_W-1:0]    cfg_r;
    logic [1:0]          tmpl_idx_r;
    logic [TMPL_W-1:0]   tmpl_r [NCH];
    logic [NCH-1:0]      tri_r;
    logic [NCH-1:0]      ais_r;
    logic [NCH-1:0]      alarm_indication_irq_mask_r;
    logic [NCH-1:0]      alarm_indication_irq_flag_r;
    logic [NCH-1:0]      alarm_indication_irq_flag_nxt;
    logic [7:0]          bank_r;

    // Bus decode
    wire       req      = cyc_i & stb_i & ~ack_r;
    wire       busy     = (srst_state_r == SR_BUSY);
    wire       wr       = req & we_i & sel_i[0] & ~busy;
    wire       rd       = req & ~we_i;
    wire [5:0] widx     = adr_i[7:2];
    wire       prim     = (bank_r == BANK_PRIMARY);
    wire       hit_srst = prim & (widx == IDX_SOFT_RST);
    wire       hit_ones = prim & (widx == IDX_AUTO_ONES);
    wire       hit_cfg  = prim & (widx == IDX_GLOBAL_CFG);
    wire       hit_tidx = prim & (widx == IDX_TMPL_CHAN);
    wire       hit_tsel = prim & (widx == IDX_TMPL_SEL);
    wire       hit_tri  = prim & (widx == IDX_DRV_TRI);
    wire       hit_stat = prim & (widx == IDX_AIS_STAT);
    wire       hit_mask = prim & (widx == IDX_AIS_MASK);
    wire       hit_flag = prim & (widx == IDX_AIS_FLAG);
    wire       hit_bank = (widx == IDX_BANK);

    wire       wen_srst = wr & hit_srst;
    wire       wen_ones = wr & hit_ones;
    wire       wen_cfg  = wr & hit_cfg;
    wire       wen_tidx = wr & hit_tidx;
    wire       wen_tsel = wr & hit_tsel;
    wire       wen_tri  = wr & hit_tri;
    wire       wen_mask = wr & hit_mask;
    wire       wen_bank = wr & hit_bank;
    wire       clr_flag = rd & hit_stat & ~busy;
    wire       hold_def = rst_i | busy;

    // Upper bits read zero; status and flag have no write path
    wire [7:0] rd_byte =
        hit_ones ? {4'h0, auto_ones_r} :
        hit_cfg  ? {1'b0, cfg_r} :
        hit_tidx ? {6'h00, tmpl_idx_r} :
        hit_tsel ? {5'h00, tmpl_r[tmpl_idx_r]} :
        hit_tri  ? {4'h0, tri_r} :
        hit_stat ? {4'h0, ais_r} :
        hit_mask ? {4'h0, alarm_indication_irq_mask_r} :
        hit_flag ? {4'h0, alarm_indication_irq_flag_r} :
        hit_bank ? bank_r :
        8'h00;

    wire [NCH-1:0] ais_edge  = ais_detect_i ^ ais_r;
    wire [NCH-1:0] flag_set  = ais_edge & alarm_indication_irq_mask_r;
    wire [NCH-1:0] flag_keep = clr_flag ? CHAN_RST : alarm_indication_irq_flag_r;
    wire [1:0]     path      = cfg_r[CFG_PATH_HI:CFG_PATH_LO];

    // Wishbone slave: ack one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req) begin
            dat_r <= {24'h00_0000, rd_byte};
        end
    end

    // Soft reset sequencer
    always_comb begin
        srst_state_nxt = srst_state_r;
        case (srst_state_r)
            SR_IDLE: begin
                if (wen_srst) begin
                    srst_state_nxt = SR_BUSY;
                end
            end
            SR_BUSY: begin
                if (srst_cnt_r == SRST_LAST) begin
                    srst_state_nxt = SR_IDLE;
                end
            end
            default: srst_state_nxt = SR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srst_state_r <= SR_IDLE;
        end else begin
            srst_state_r <= srst_state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !busy) begin
            srst_cnt_r <= 4'h0;
        end else begin
            srst_cnt_r <= srst_cnt_r + 4'h1;
        end
    end

    // Length of the running soft reset, kept apart from the sequencer count
    logic [3:0]          busy_run_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || !busy) begin
            busy_run_r <= 4'h0;
        end else begin
            busy_run_r <= busy_run_r + 4'h1;
        end
    end

    // Control registers, held at defaults through a soft reset
    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            auto_ones_r <= CHAN_RST;
        end else if (wen_ones) begin
            auto_ones_r <= dat_i[NCH-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            cfg_r <= CFG_RST;
        end else if (wen_cfg) begin
            cfg_r <= dat_i[CFG_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            tmpl_idx_r <= IDX_RST;
        end else if (wen_tidx) begin
            tmpl_idx_r <= dat_i[1:0];
        end
    end

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_chan
            wire sel_c = wen_tsel & (tmpl_idx_r == 2'(c));
            always_ff @(posedge clk_i) begin
                if (hold_def) begin
                    tmpl_r[c] <= TMPL_RST;
                end else if (sel_c) begin
                    tmpl_r[c] <= dat_i[TMPL_W-1:0];
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    template_o[c*TMPL_W +: TMPL_W] <= TMPL_RST;
                end else begin
                    template_o[c*TMPL_W +: TMPL_W] <= tmpl_r[c];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            tri_r <= CHAN_RST;
        end else if (wen_tri) begin
            tri_r <= dat_i[NCH-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            alarm_indication_irq_mask_r <= CHAN_RST;
        end else if (wen_mask) begin
            alarm_indication_irq_mask_r <= dat_i[NCH-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            bank_r <= BANK_PRIMARY;
        end else if (wen_bank) begin
            bank_r <= dat_i[7:0];
        end
    end

    // Alarm status follows the detector; flags are sticky
    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            ais_r <= CHAN_RST;
        end else begin
            ais_r <= ais_detect_i;
        end
    end

    // A new edge wins over a clearing read in the same cycle
    assign alarm_indication_irq_flag_nxt = flag_keep | flag_set;

    always_ff @(posedge clk_i) begin
        if (hold_def) begin
            alarm_indication_irq_flag_r <= CHAN_RST;
        end else begin
            alarm_indication_irq_flag_r <= alarm_indication_irq_flag_nxt;
        end
    end

    // Registered block outputs; bit n serves channel n
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            all_ones_o   <= CHAN_RST;
            ais_insert_o <= CHAN_RST;
            driver_hiz_o <= CHAN_RST;
        end else begin
            all_ones_o   <= auto_ones_r & no_signal_alarm_i;
            ais_insert_o <= {NCH{cfg_r[CFG_ALARM_INS]}}
                            & no_signal_alarm_i;
            driver_hiz_o <= tri_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_prot_en_o <= 1'b1;
            ami_sel_o       <= 1'b0;
            fifo_deep_o     <= 1'b0;
            bw_high_o       <= 1'b0;
            ja_tx_o         <= 1'b0;
            ja_rx_o         <= 1'b0;
        end else begin
            short_prot_en_o <= ~cfg_r[CFG_SCP_BYP];
            ami_sel_o       <= cfg_r[CFG_LINE_CODE];
            fifo_deep_o     <= cfg_r[CFG_FIFO_DEP];
            bw_high_o       <= cfg_r[CFG_BW_SEL];
            ja_tx_o         <= (path == PATH_TX);
            ja_rx_o         <= (path == PATH_RX);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_exp_o  <= 1'b0;
            srst_busy_o <= 1'b0;
            irq_o       <= 1'b0;
        end else begin
            bank_exp_o  <= (bank_r == BANK_EXPANDED);
            srst_busy_o <= busy;
            irq_o       <= |(alarm_indication_irq_flag_r & alarm_indication_irq_mask_r);
        end
    end

    assign dat_o = dat_r;
    assign ack_o = ack_r;

    // Checks
    all_ones_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 all_ones_o == ($past(auto_ones_r) & $past(no_signal_alarm_i))
    ) else $error("all ones output mismatch");

    ais_ins_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!cfg_r[CFG_ALARM_INS]) |=> (ais_insert_o == CHAN_RST)
    ) else $error("alarm inserted while disabled");

    scp_on_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wen_cfg |-> ##2 (short_prot_en_o == ~$past(dat_i[CFG_SCP_BYP], 2))
    ) else $error("short protection state wrong");

    path_sel_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (path == 2'h2) |=> (!ja_tx_o && !ja_rx_o)
    ) else $error("attenuator placed for unused code");

    tmpl_wr_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wen_tsel |=> (tmpl_r[$past(tmpl_idx_r)] == $past(dat_i[2:0]))
    ) else $error("template write went astray");

    hiz_out_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wen_tri |-> ##2 (driver_hiz_o == $past(dat_i[3:0], 2))
    ) else $error("driver high impedance mismatch");

    flag_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i || busy)
        (|flag_set) |=> ((alarm_indication_irq_flag_r & $past(flag_set)) == $past(flag_set))
    ) else $error("masked transition not flagged");

    flag_clr_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (clr_flag && flag_set == CHAN_RST) |=> (alarm_indication_irq_flag_r == CHAN_RST)
    ) else $error("status read did not clear flags");

    no_unmask_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (alarm_indication_irq_mask_r == CHAN_RST) |=> ($stable(alarm_indication_irq_flag_r) || alarm_indication_irq_flag_r == CHAN_RST)
    ) else $error("flag set while masked");

    srst_go_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wen_srst |=> busy
    ) else $error("soft reset did not start");

    srst_len_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(busy) |-> (busy_run_r == 4'(SRST_CYC))
    ) else $error("soft reset length wrong");

    srst_def_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        busy |=> (cfg_r == CFG_RST && bank_r == BANK_PRIMARY)
    ) else $error("defaults not held in soft reset");

    bank_map_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !prim && widx == IDX_GLOBAL_CFG) |=> (dat_o == 32'h0)
    ) else $error("primary register seen off bank");

    ro_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr && hit_flag && flag_set == CHAN_RST) |=> $stable(alarm_indication_irq_flag_r)
    ) else $error("flag register took a write");

    bus_ack_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o
    ) else $error("bus ack timing wrong");

    boot_bank_a: assert property (
        @(posedge clk_i)
        $fell(rst_i) |-> (bank_r == BANK_PRIMARY)
    ) else $error("bank pointer not primary after reset");
endmodule : lipr_regs
`default_nettype wire

/* File: dv/lipr_host_model.sv */
// Wishbone host model issuing classic single cycles to the register block
`timescale 1ns/1ps
`default_nettype none
module lipr_host_model (
    input  wire logic                       clk_i, // Bus clock
    input  wire logic [lipr_pkg::DAT_W-1:0] dat_i, // Read data
    input  wire logic                       ack_i, // Acknowledge
    output logic                            cyc_o, // Cycle
    output logic                            stb_o, // Strobe
    output logic                            we_o,  // Write
    output logic      [lipr_pkg::ADR_W-1:0] adr_o, // Byte address
    output logic      [lipr_pkg::SEL_W-1:0] sel_o, // Byte enables
    output logic      [lipr_pkg::DAT_W-1:0] dat_o  // Write data
);
    import lipr_pkg::*;

    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One request held until ack is sampled high, then released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= {24'h0, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
    endtask : xfer
endmodule : lipr_host_model
`default_nettype wire

/* File: dv/lipr_regs_tb.sv */
// Self-checking testbench for the primary register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) cmp(32'(g), 32'(e))
module lipr_regs_tb;
    import lipr_pkg::*;

    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} lipr_row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel, no_signal_alarm, alarm_indication_status, all_ones, ais_ins, hiz;
    logic [31:0] wdat, rdat, q;
    logic        scp, ami, deep, bw, jtx, jrx, bank_exp, busy, irq;
    logic [11:0] tmpl;
    int          bad_count = 0;
    int          checks = 0;
    int          n;
    lipr_row_t   rows[8] = '{'{8'h38, 8'h0A, 8'h0A}, '{8'h3C, 8'h7F, 8'h7F},
                             '{8'h40, 8'h02, 8'h02}, '{8'h48, 8'h09, 8'h09},
                             '{8'h50, 8'h0F, 8'h0F}, '{8'h4C, 8'h0F, 8'h00},
                             '{8'h54, 8'h0F, 8'h00}, '{8'h60, 8'h5A, 8'h00}};
    logic [7:0]  radr[9] = '{8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h7C};
    logic [7:0]  cfgs[6] = '{8'h00, 8'h7F, 8'h55, 8'h2A, 8'h01, 8'h02};

    initial begin
        forever #50 clk = ~clk;
    end

    initial begin
        no_signal_alarm = 4'h0;
        alarm_indication_status = 4'h0;
    end

    lipr_host_model host_u (.clk_i(clk), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    lipr_regs dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .no_signal_alarm_i(no_signal_alarm), .ais_detect_i(alarm_indication_status), .all_ones_o(all_ones),
        .ais_insert_o(ais_ins), .short_prot_en_o(scp), .ami_sel_o(ami), .fifo_deep_o(deep),
        .bw_high_o(bw), .ja_tx_o(jtx), .ja_rx_o(jrx), .template_o(tmpl),
        .driver_hiz_o(hiz), .bank_exp_o(bank_exp), .srst_busy_o(busy), .irq_o(irq));

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] dummy;
        host_u.xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle

    task automatic test_done;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        #2000000;
        bad_count++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        `CHK(scp, 1'b1);
        foreach (radr[i]) begin
            host_u.xfer(1'b0, radr[i], 8'h00, q);
            `CHK(q, 32'h0);
        end
        // Write and read-back rows, with read-only and unmapped addresses reading zero
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            host_u.xfer(1'b0, rows[i].a, 8'h00, q);
            `CHK(q, {24'h0, rows[i].r});
        end
        settle(2);
        `CHK(hiz, 4'h9);
        // Configuration field decode
        foreach (cfgs[i]) begin
            wr(8'h3C, cfgs[i]);
            settle(2);
            `CHK({scp, ami, deep, bw}, {~cfgs[i][5], cfgs[i][4:2]});
            `CHK({jtx, jrx}, {cfgs[i][1:0] == PATH_TX, cfgs[i][1:0] == PATH_RX});
        end
        // Loss-driven all-ones and alarm insertion
        wr(8'h38, 8'h05);
        @(posedge clk);
        no_signal_alarm <= 4'h6;
        settle(3);
        `CHK(all_ones, 4'h4);
        `CHK(ais_ins, 4'h0);
        wr(8'h3C, 8'h40);
        settle(2);
        `CHK(ais_ins, 4'h6);
        // Indirect template access, every code
        for (int c = 0; c < 8; c++) begin
            wr(8'h40, 8'(c % 4));
            wr(8'h44, 8'(c));
            host_u.xfer(1'b0, 8'h44, 8'h00, q);
            `CHK(q, c);
        end
        settle(2);
        `CHK(tmpl, {3'h7, 3'h6, 3'h5, 3'h4});
        // Alarm indication status, mask and flags
        wr(8'h50, 8'h02);
        @(posedge clk);
        alarm_indication_status <= 4'h3;
        settle(4);
        `CHK(irq, 1'b1);
        host_u.xfer(1'b0, 8'h54, 8'h00, q);
        `CHK(q, 32'h2);
        host_u.xfer(1'b0, 8'h4C, 8'h00, q);
        `CHK(q, 32'h3);
        host_u.xfer(1'b0, 8'h54, 8'h00, q);
        `CHK(q, 32'h0);
        settle(2);
        `CHK(irq, 1'b0);
        @(posedge clk);
        alarm_indication_status <= 4'h1;
        settle(4);
        host_u.xfer(1'b0, 8'h54, 8'h00, q);
        `CHK(q, 32'h2);
        wr(8'h50, 8'h00);
        settle(2);
        `CHK(irq, 1'b0);
        // Bank pointer
        wr(8'h7C, BANK_EXPANDED);
        settle(2);
        `CHK(bank_exp, 1'b1);
        host_u.xfer(1'b0, 8'h48, 8'h00, q);
        `CHK(q, 32'h0);
        host_u.xfer(1'b0, 8'h7C, 8'h00, q);
        `CHK(q, 32'hAA);
        wr(8'h7C, 8'h55);
        settle(2);
        `CHK(bank_exp, 1'b0);
        wr(8'h7C, BANK_PRIMARY);
        host_u.xfer(1'b0, 8'h48, 8'h00, q);
        `CHK(q, 32'h9);
        // Soft reset cycle length and defaults
        wr(8'h28, 8'h00);
        n = 0;
        settle(0);
        for (int k = 0; k < 5 && busy !== 1'b1; k++) settle(1);
        while (busy === 1'b1 && n < 40) begin
            n++;
            settle(1);
        end
        `CHK(n, SRST_CYC);
        settle(1);
        `CHK({hiz, scp, all_ones}, {4'h0, 1'b1, 4'h0});
        host_u.xfer(1'b0, 8'h44, 8'h00, q);
        `CHK(q, 32'h0);
        // Second hard reset in mid-run
        wr(8'h48, 8'h0F);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        `CHK(hiz, 4'h0);
        host_u.xfer(1'b0, 8'h48, 8'h00, q);
        `CHK(q, 32'h0);
        test_done();
    end
endmodule : lipr_regs_tb
`default_nettype wire

/* File: include/lipr_pkg.sv */
// Constants and types for the line interface primary register block
package lipr_pkg;
    localparam int unsigned NCH      = 4;
    localparam int unsigned ADR_W    = 8;
    localparam int unsigned DAT_W    = 32;
    localparam int unsigned SEL_W    = 4;
    localparam int unsigned TMPL_W   = 3;
    localparam int unsigned CFG_W    = 7;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_SOFT_RST   = 6'h0A;
    localparam logic [5:0] IDX_AUTO_ONES  = 6'h0E;
    localparam logic [5:0] IDX_GLOBAL_CFG = 6'h0F;
    localparam logic [5:0] IDX_TMPL_CHAN  = 6'h10;
    localparam logic [5:0] IDX_TMPL_SEL   = 6'h11;
    localparam logic [5:0] IDX_DRV_TRI    = 6'h12;
    localparam logic [5:0] IDX_AIS_STAT   = 6'h13;
    localparam logic [5:0] IDX_AIS_MASK   = 6'h14;
    localparam logic [5:0] IDX_AIS_FLAG   = 6'h15;
    localparam logic [5:0] IDX_BANK       = 6'h1F;

    localparam logic [7:0] BANK_PRIMARY   = 8'h00;
    localparam logic [7:0] BANK_EXPANDED  = 8'hAA;

    // Global configuration field positions
    localparam int unsigned CFG_ALARM_INS = 6;
    localparam int unsigned CFG_SCP_BYP   = 5;
    localparam int unsigned CFG_LINE_CODE = 4;
    localparam int unsigned CFG_FIFO_DEP  = 3;
    localparam int unsigned CFG_BW_SEL    = 2;
    localparam int unsigned CFG_PATH_HI   = 1;
    localparam int unsigned CFG_PATH_LO   = 0;

    localparam logic [1:0] PATH_TX        = 2'h1;
    localparam logic [1:0] PATH_RX        = 2'h3;

    localparam logic [3:0]        CHAN_RST = 4'h0;
    localparam logic [CFG_W-1:0]  CFG_RST  = 7'h00;
    localparam logic [1:0]        IDX_RST  = 2'h0;
    localparam logic [TMPL_W-1:0] TMPL_RST = 3'h0;

    // Soft reset cycle length
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SRST_NS       = 1000;
    localparam int unsigned SRST_CYC      =
        (SRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  SRST_LAST     = 4'(SRST_CYC - 1);

    typedef enum logic [1:0] {
        SR_IDLE = 2'b01,
        SR_BUSY = 2'b10
    } lipr_srst_t;
endpackage : lipr_pkg
